// [hw/sse_exec.sv]
// Executor for the power-down and the two subtract instructions, with an APB slave
//
// Functional notes
// - Power-down clears watchdog counter and prescaler
// - Power-down clears powerdown_flag, sets timeout_flag only
// - Power-down halts oscillator; no execution until wake
// - Literal subtract: literal minus W into W
// - File subtract: file register minus W, 7-bit address
// - Destination bit picks W (0) or file (1)
// - Carry set when no borrow, cleared on borrow
`timescale 1ns/1ps
module sse_exec
  import sse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic watchdog_clear,
  output logic watchdog_prescaler_clear,
  output logic osc_stop,
  output logic timeout_flag,
  output logic powerdown_flag
);

  // ********************************************************************
  // Types and helpers
  // ********************************************************************
  typedef struct packed {
    sse_state_e st;
    logic [13:0] instr;
    logic [7:0] w;
    sse_status_s stat;
    logic [7:0] prdata;
    logic pready;
    logic pslverr;
    logic watchdog_clr;
    logic osc_stop;
  } sse_core_s;

  // Two's complement a - w with no-borrow carries
  function automatic sse_sub_s sse_sub(input logic [7:0] a, input logic [7:0] w);
    logic [8:0] full;
    logic [4:0] nib;
    sse_sub_s s;
    full = {1'b0, a} - {1'b0, w};
    nib = {1'b0, a[3:0]} - {1'b0, w[3:0]};
    s.res = full[7:0];
    s.c = ~full[8];
    s.nib_c = ~nib[4];
    s.z = (full[7:0] == 8'h00);
    return s;
  endfunction : sse_sub

  // Merge subtract flags, leaving power flags alone
  function automatic sse_status_s sse_put(input sse_status_s o, input sse_sub_s s);
    sse_status_s n;
    n = o;
    n.c = s.c;
    n.digit_carry_flag = s.nib_c;
    n.z = s.z;
    return n;
  endfunction : sse_put

  sse_core_s q_r;
  sse_core_s q_nxt;
  logic mem_re;
  logic mem_we;
  logic [6:0] mem_addr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic acc;
  logic ex_sleep;
  logic ex_lit;
  logic ex_file;
  sse_sub_s sub_lit;
  sse_sub_s sub_file;

  // ********************************************************************
  // File register storage
  // ********************************************************************
  sse_file_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .re(mem_re),
    .we(mem_we),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  // Subtract units for both instruction forms
  assign sub_lit = sse_sub(pwdata[7:0], q_r.w);
  assign sub_file = sse_sub(mem_rdata, q_r.w);

  // ********************************************************************
  // Next-state logic: APB decode and instruction execution
  // ********************************************************************
  always_comb begin
    q_nxt = q_r;
    q_nxt.watchdog_clr = 1'b0;
    mem_re = 1'b0;
    mem_we = 1'b0;
    mem_addr = paddr[8:2];
    mem_wdata = pwdata[7:0];
    ex_sleep = 1'b0;
    ex_lit = 1'b0;
    ex_file = 1'b0;
    // Access phase not yet answered; pready high blocks a double take
    acc = psel && penable && !q_r.pready;
    if (q_r.pready) begin
      q_nxt.pready = 1'b0;
      q_nxt.pslverr = 1'b0;
    end
    case (q_r.st)
      SSE_IDLE, SSE_SLEEP: begin
        if (acc) begin
          q_nxt.pready = 1'b1;
          q_nxt.pslverr = 1'b0;
          q_nxt.prdata = 8'h00;
          if (paddr[11:9] == SSE_FR_SEL) begin
            if (pwrite) begin
              mem_we = 1'b1;
            end else begin
              // Memory read is registered, so answer a cycle later
              mem_re = 1'b1;
              q_nxt.pready = 1'b0;
              q_nxt.st = SSE_MRD;
            end
          end else begin
            case (paddr)
              SSE_OFF_INSTR: begin
                if (!pwrite) begin
                  q_nxt.prdata = q_r.instr[7:0];
                end else if (q_r.osc_stop) begin
                  // Core is asleep: the word is refused
                  q_nxt.pslverr = 1'b1;
                end else begin
                  q_nxt.instr = pwdata[13:0];
                  if (pwdata[13:0] == SSE_OP_SLEEP) begin
                    ex_sleep = 1'b1;
                    q_nxt.watchdog_clr = 1'b1;
                    q_nxt.stat.powerdown_flag = 1'b0;
                    q_nxt.stat.timeout_flag = 1'b1;
                    q_nxt.osc_stop = 1'b1;
                    q_nxt.st = SSE_SLEEP;
                  end else if (pwdata[13:9] == SSE_OP_LIT_SUB) begin
                    ex_lit = 1'b1;
                    q_nxt.w = sub_lit.res;
                    q_nxt.stat = sse_put(q_r.stat, sub_lit);
                  end else if (pwdata[13:8] == SSE_OP_FILE_SUB) begin
                    ex_file = 1'b1;
                    mem_re = 1'b1;
                    mem_addr = pwdata[6:0];
                    q_nxt.pready = 1'b0;
                    q_nxt.st = SSE_FRD;
                  end
                end
              end
              SSE_OFF_WREG: begin
                if (pwrite) begin
                  q_nxt.w = pwdata[7:0];
                end else begin
                  q_nxt.prdata = q_r.w;
                end
              end
              SSE_OFF_STATUS: begin
                if (pwrite) begin
                  // Power flags stay read-only to software
                  q_nxt.stat.c = pwdata[SSE_ST_C];
                  q_nxt.stat.digit_carry_flag = pwdata[SSE_ST_DIGIT_CARRY];
                  q_nxt.stat.z = pwdata[SSE_ST_Z];
                end else begin
                  q_nxt.prdata = {2'b00, q_r.osc_stop, q_r.stat};
                end
              end
              SSE_OFF_CTRL: begin
                if (pwrite) begin
                  if (pwdata[SSE_CTRL_WAKE] && q_r.osc_stop) begin
                    q_nxt.osc_stop = 1'b0;
                    q_nxt.st = SSE_IDLE;
                  end
                end else begin
                  q_nxt.prdata = {7'h00, q_r.osc_stop};
                end
              end
              default: begin
                q_nxt.pslverr = 1'b1;
              end
            endcase
          end
        end
      end
      SSE_MRD: begin
        q_nxt.prdata = mem_rdata;
        q_nxt.pready = 1'b1;
        q_nxt.st = q_r.osc_stop ? SSE_SLEEP : SSE_IDLE;
      end
      SSE_FRD: begin
        mem_addr = q_r.instr[6:0];
        mem_wdata = sub_file.res;
        q_nxt.stat = sse_put(q_r.stat, sub_file);
        if (q_r.instr[SSE_D_BIT]) begin
          mem_we = 1'b1;
        end else begin
          q_nxt.w = sub_file.res;
        end
        q_nxt.pready = 1'b1;
        q_nxt.st = SSE_IDLE;
      end
      default: begin
        q_nxt.st = SSE_IDLE;
      end
    endcase
  end

  // State register; ce low freezes everything
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r.st <= SSE_IDLE;
      q_r.instr <= SSE_INSTR_RST;
      q_r.w <= SSE_W_RST;
      q_r.stat <= SSE_STATUS_RST;
      q_r.prdata <= 8'h00;
      q_r.pready <= 1'b0;
      q_r.pslverr <= 1'b0;
      q_r.watchdog_clr <= 1'b0;
      q_r.osc_stop <= 1'b0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  // ********************************************************************
  // Outputs, all straight from flops
  // ********************************************************************
  assign prdata = {24'h000000, q_r.prdata};
  assign pready = q_r.pready;
  assign pslverr = q_r.pslverr;
  assign watchdog_clear = q_r.watchdog_clr;
  assign watchdog_prescaler_clear = q_r.watchdog_clr;
  assign osc_stop = q_r.osc_stop;
  assign timeout_flag = q_r.stat.timeout_flag;
  assign powerdown_flag = q_r.stat.powerdown_flag;

  // ********************************************************************
  // Assertions
  // ********************************************************************
  sleep_wdt_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ex_sleep) |=> (watchdog_clear && watchdog_prescaler_clear))
    else $error("power-down did not clear watchdog");

  sleep_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ex_sleep) |=> (timeout_flag && !powerdown_flag && $stable(q_r.stat.c)
      && $stable(q_r.stat.z) && $stable(q_r.stat.digit_carry_flag)))
    else $error("power-down status flags wrong");

  sleep_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ex_sleep) |=> (osc_stop && q_r.st == SSE_SLEEP) ##1 ($stable(q_r.w)
      && $stable(q_r.instr)))
    else $error("core ran after power-down");

  sleep_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && q_r.osc_stop && acc && pwrite && paddr == SSE_OFF_INSTR)
      |=> (pslverr && pready && q_r.w == $past(q_r.w)))
    else $error("instruction executed while asleep");

  lit_sub_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ex_lit) |=> (q_r.w == 8'($past(pwdata[7:0]) - $past(q_r.w))))
    else $error("literal subtract result wrong");

  file_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ex_file) |=> (q_r.st == SSE_FRD && mem_addr == q_r.instr[6:0]))
    else $error("file subtract addressed wrong register");

  file_dest_a: assert property (@(posedge pclk) disable iff (!presetn)
    (q_r.st == SSE_FRD) |-> (mem_we == q_r.instr[SSE_D_BIT]))
    else $error("file subtract destination wrong");

  file_w_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && q_r.st == SSE_FRD && !q_r.instr[SSE_D_BIT])
      |=> (q_r.w == 8'($past(mem_rdata) - $past(q_r.w))))
    else $error("file subtract did not load W");

  carry_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && q_r.st == SSE_FRD) |=> (q_r.stat.c == ($past(mem_rdata) >= $past(q_r.w))))
    else $error("carry not equal to no-borrow");

  zero_dc_a: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && ex_lit) |=> ((q_r.stat.z == (q_r.w == 8'h00)) && (q_r.stat.digit_carry_flag
      == ($past(pwdata[3:0]) >= $past(q_r.w[3:0])))))
    else $error("zero or digit carry flag wrong");

  // Main scenarios
  sleep_c: cover property (@(posedge pclk) disable iff (!presetn) ce && ex_sleep);
  lit_neg_c: cover property (@(posedge pclk) disable iff (!presetn)
    ce && ex_lit && !sub_lit.c);
  file_back_c: cover property (@(posedge pclk) disable iff (!presetn)
    ce && q_r.st == SSE_FRD && q_r.instr[SSE_D_BIT] && sub_file.z);
  wake_c: cover property (@(posedge pclk) disable iff (!presetn)
    q_r.osc_stop ##1 !q_r.osc_stop);

endmodule : sse_exec

// [common/sse_pkg.sv]
// Package: constants, types and encodings for the power-down and subtract executor
package sse_pkg;

  // ********************************************************************
  // APB register map (byte addresses)
  // ********************************************************************
  localparam int SSE_AW = 12;
  localparam logic [11:0] SSE_OFF_INSTR = 12'h000;
  localparam logic [11:0] SSE_OFF_WREG = 12'h004;
  localparam logic [11:0] SSE_OFF_STATUS = 12'h008;
  localparam logic [11:0] SSE_OFF_CTRL = 12'h00c;
  // File registers 0..127 sit at base + 4*index
  localparam logic [2:0] SSE_FR_SEL = 3'h1;
  localparam int SSE_FR_DEPTH = 128;

  // ********************************************************************
  // Status register bit positions and reset values
  // ********************************************************************
  localparam int SSE_ST_C = 0;
  localparam int SSE_ST_DIGIT_CARRY = 1;
  localparam int SSE_ST_Z = 2;
  localparam int SSE_ST_POWERDOWN = 3;
  localparam int SSE_ST_TIMEOUT = 4;
  localparam int SSE_ST_SLP = 5;
  localparam int SSE_CTRL_WAKE = 0;
  localparam logic [7:0] SSE_W_RST = 8'h00;
  localparam logic [13:0] SSE_INSTR_RST = 14'h0000;

  // ********************************************************************
  // Instruction encodings
  // ********************************************************************
  localparam logic [13:0] SSE_OP_SLEEP = 14'h0063;
  localparam logic [4:0] SSE_OP_LIT_SUB = 5'h1e;
  localparam logic [5:0] SSE_OP_FILE_SUB = 6'h02;
  localparam int SSE_D_BIT = 7;

  // Flags in the status word
  typedef struct packed {
    logic timeout_flag;
    logic powerdown_flag;
    logic z;
    logic digit_carry_flag;
    logic c;
  } sse_status_s;

  localparam sse_status_s SSE_STATUS_RST = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};

  // Subtract result with its flags
  typedef struct packed {
    logic [7:0] res;
    logic c;
    logic nib_c;
    logic z;
  } sse_sub_s;

  typedef enum logic [4:0] {
    SSE_IDLE = 5'b00001,
    SSE_MRD = 5'b00010,
    SSE_FRD = 5'b00100,
    SSE_SLEEP = 5'b01000,
    SSE_SPARE = 5'b10000
  } sse_state_e;

endpackage : sse_pkg

// [hw/sse_file_mem.sv]
// File register memory: 128 bytes, registered read data
`timescale 1ns/1ps
module sse_file_mem
  import sse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic re,
  input wire logic we,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);

  typedef struct packed {
    logic [SSE_FR_DEPTH-1:0][7:0] mem;
    logic [7:0] rdata;
  } sse_mem_s;

  sse_mem_s q_r;
  sse_mem_s q_nxt;

  // ********************************************************************
  // Next state: write port and registered read port
  // ********************************************************************
  always_comb begin
    q_nxt = q_r;
    if (we) begin
      q_nxt.mem[addr] = wdata;
    end
    if (re) begin
      q_nxt.rdata = q_r.mem[addr];
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q_r <= '0;
    end else if (ce) begin
      q_r <= q_nxt;
    end
  end

  assign rdata = q_r.rdata;

endmodule : sse_file_mem

// [bench/sse_exec_tb.sv]
// Self-checking bench for the power-down and subtract executor over APB
`timescale 1ns/1ps
module sse_exec_tb
  import sse_pkg::*;
;
  // ********************************************************************
  // Clock, reset and bus signals
  // ********************************************************************
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic watchdog_clear;
  logic watchdog_prescaler_clear;
  logic osc_stop;
  logic timeout_flag;
  logic powerdown_flag;
  int fail_count = 0;
  int cmp_count = 0;
  int clear_cycles = 0;
  logic [31:0] last_rd;
  logic last_err;
  logic [2:0] fl;
  logic [7:0] res;

  sse_exec dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_clear(watchdog_clear),
    .watchdog_prescaler_clear(watchdog_prescaler_clear),
    .osc_stop(osc_stop), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag));

  // 200 MHz clock
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // Count cycles with both watchdog clears high, so a stretched pulse shows
  always @(posedge pclk) begin
    if (watchdog_clear === 1'b1 && watchdog_prescaler_clear === 1'b1) clear_cycles++;
  end

  // ********************************************************************
  // Shared tasks
  // ********************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the hang guard ends a lost answer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so the next request never reassigns psel in this step
    @(posedge pclk);
  endtask : apb

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  // Flags {z, dc, c} of a - b: carry and digit carry mean no borrow
  function automatic logic [2:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {r == 8'h00, a[3:0] >= b[3:0], a >= b};
  endfunction : sub_flags

  // Hang guard, well above the expected few hundred cycles
  initial begin
    #60000;
    fail_count++;
    conclude();
  end

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  localparam logic [7:0] LW [5] = '{8'h01, 8'h02, 8'h03, 8'h10, 8'hff};
  localparam logic [7:0] LK [5] = '{8'h02, 8'h02, 8'h02, 8'h01, 8'h00};
  localparam logic [6:0] FA [4] = '{7'd127, 7'd0, 7'd5, 7'd64};
  localparam logic [7:0] FV [4] = '{8'h03, 8'h02, 8'h01, 8'h80};
  localparam logic [7:0] FW [4] = '{8'h02, 8'h02, 8'h02, 8'h81};
  localparam logic FD [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // Reset state of flags and registers
    chk({31'h0, timeout_flag}, 32'h1);
    chk({31'h0, powerdown_flag}, 32'h1);
    apb(1'b0, SSE_OFF_STATUS, 32'h0);
    chk(last_rd, 32'h18);
    apb(1'b0, 12'h100, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    chk(last_rd, 32'h0);
    $display("test reset_and_unmapped done");
    // Literal subtract, both encodings of the don't-care opcode bit
    for (int i = 0; i < 5; i++) begin
      res = LK[i] - LW[i];
      fl = sub_flags(LK[i], LW[i]);
      apb(1'b1, SSE_OFF_WREG, {24'h0, LW[i]});
      apb(1'b1, SSE_OFF_INSTR, {18'h0, SSE_OP_LIT_SUB, i[0], LK[i]});
      chk({31'h0, last_err}, 32'h0);
      apb(1'b0, SSE_OFF_WREG, 32'h0);
      chk(last_rd, {24'h0, res});
      apb(1'b0, SSE_OFF_STATUS, 32'h0);
      chk(last_rd, {26'h0, 3'b011, fl});
    end
    $display("test literal_subtract done");
    // File subtract with both destinations and boundary addresses
    for (int i = 0; i < 4; i++) begin
      res = FV[i] - FW[i];
      fl = sub_flags(FV[i], FW[i]);
      apb(1'b1, 12'h200 + {3'h0, FA[i], 2'b00}, {24'h0, FV[i]});
      apb(1'b1, SSE_OFF_WREG, {24'h0, FW[i]});
      apb(1'b1, SSE_OFF_INSTR, {18'h0, SSE_OP_FILE_SUB, FD[i], FA[i]});
      apb(1'b0, SSE_OFF_WREG, 32'h0);
      chk(last_rd, {24'h0, FD[i] ? FW[i] : res});
      apb(1'b0, 12'h200 + {3'h0, FA[i], 2'b00}, 32'h0);
      chk(last_rd, {24'h0, FD[i] ? res : FV[i]});
      apb(1'b0, SSE_OFF_STATUS, 32'h0);
      chk(last_rd, {26'h0, 3'b011, fl});
    end
    $display("test file_subtract done");
    // Power-down keeps arithmetic flags and stops further execution
    apb(1'b1, SSE_OFF_STATUS, 32'h5);
    apb(1'b1, SSE_OFF_WREG, 32'h44);
    apb(1'b1, SSE_OFF_INSTR, {18'h0, SSE_OP_SLEEP});
    chk({31'h0, last_err}, 32'h0);
    chk(clear_cycles, 32'h1);
    chk({29'h0, osc_stop, timeout_flag, powerdown_flag}, 32'h6);
    apb(1'b0, SSE_OFF_STATUS, 32'h0);
    chk(last_rd, 32'h35);
    apb(1'b1, SSE_OFF_INSTR, {18'h0, SSE_OP_LIT_SUB, 1'b0, 8'h01});
    chk({31'h0, last_err}, 32'h1);
    apb(1'b0, SSE_OFF_WREG, 32'h0);
    chk(last_rd, 32'h44);
    apb(1'b0, SSE_OFF_CTRL, 32'h0);
    chk(last_rd, 32'h1);
    apb(1'b1, SSE_OFF_CTRL, 32'h1);
    chk({31'h0, osc_stop}, 32'h0);
    chk(clear_cycles, 32'h1);
    $display("test power_down done");
    // After wake the subtract runs again and power-down flags hold
    apb(1'b1, SSE_OFF_INSTR, {18'h0, SSE_OP_LIT_SUB, 1'b1, 8'h40});
    apb(1'b0, SSE_OFF_WREG, 32'h0);
    chk(last_rd, 32'hfc);
    // 0x40 - 0x44 borrows in both nibbles: carry and digit carry clear
    apb(1'b0, SSE_OFF_STATUS, 32'h0);
    chk(last_rd, 32'h10);
    $display("test wake_and_resume done");
    conclude();
  end
endmodule : sse_exec_tb
